// >>> pkg/uart_cfg_pkg.sv
// constants, enums and structs for the serial transceiver control block
`default_nettype none
package uart_cfg_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_LINE_CTRL    = 4'h5; // interrupt enable and rs485
   localparam logic [3:0] ADDR_LINE_ENABLE  = 4'h6;
   localparam logic [3:0] ADDR_FRAME_FORMAT = 4'h7;
   localparam logic [3:0] ADDR_STATUS       = 4'h4;
   localparam logic [3:0] ADDR_TX_LOW       = 4'h2;
   localparam logic [3:0] ADDR_TX_HIGH      = 4'h3;

   localparam logic [7:0] RESET_LINE_CTRL   = 8'h00;
   localparam logic [7:0] RESET_LINE_ENABLE = 8'h00;
   localparam logic [7:0] RESET_FRAME       = 8'h03;
   localparam logic [7:0] RESET_FRAME_SPI   = 8'h02;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int BIT_RS485        = 0;
   localparam int BIT_BAUD_ERR_IE  = 2;
   localparam int BIT_RX_ON        = 7;
   localparam int BIT_TX_ON        = 6;
   localparam int BIT_SFD_ON       = 4;
   localparam int BIT_OPEN_DRAIN   = 3;
   localparam int BIT_MULTI_NODE   = 0;
   localparam int BIT_STOP_COUNT   = 3;
   localparam int BIT_BIT_ORDER    = 2;
   localparam int BIT_CLOCK_PHASE  = 1;
   localparam int BIT_BAD_SYNC     = 3;
   localparam logic [7:0] MASK_LINE_CTRL   = 8'h05;
   localparam logic [7:0] MASK_LINE_ENABLE = 8'hDF;
   localparam logic [7:0] MASK_SPI_VIEW    = 8'hC6;
   localparam logic [7:0] SYNC_CHAR        = 8'h55;

   typedef enum logic [1:0] {
      SPEED_NORMAL = 2'b00,
      SPEED_DOUBLE = 2'b01,
      SPEED_GENERIC_AUTO = 2'b10,
      SPEED_LIN_AUTO = 2'b11
   } receiver_speed_select_e;

   typedef enum logic [1:0] {
      LINK_ASYNC = 2'b00,
      LINK_SYNC = 2'b01,
      LINK_INFRARED = 2'b10,
      LINK_HOST_SPI = 2'b11
   } link_mode_select_e;

   typedef enum logic [1:0] {
      PARITY_NONE = 2'b00,
      PARITY_RESERVED = 2'b01,
      PARITY_EVEN = 2'b10,
      PARITY_ODD = 2'b11
   } parity_select_e;

   typedef enum logic [2:0] {
      WIDTH_5 = 3'b000,
      WIDTH_6 = 3'b001,
      WIDTH_7 = 3'b010,
      WIDTH_8 = 3'b011,
      WIDTH_RES4 = 3'b100,
      WIDTH_RES5 = 3'b101,
      NINE_BIT_LOW_FIRST = 3'b110,
      NINE_BIT_HIGH_FIRST = 3'b111
   } character_width_e;

   typedef struct packed {
      logic                   receiver_on;
      logic                   transmitter_on;
      logic                   frame_start_detect_on;
      logic                   open_drain_on;
      receiver_speed_select_e receiver_speed_select;
      logic                   multi_node_addressing;
      logic                   rs485_on;
      link_mode_select_e      link_mode_select;
      parity_select_e         parity_select;
      logic                   two_stop_bits;
      character_width_e       character_width;
      logic [3:0]             data_bits;
      logic                   lsb_first;
      logic                   sample_trailing;
   } line_config_s;
endpackage
`default_nettype wire

// >>> core/uart_control_config.sv
// control and configuration registers of a serial transceiver
// Behaviour
// (R1) baud error interrupt requested while bad sync flag set and enable set
// (R2) control bit 0 turns rs485 operation on or off
// (R3) line enable bit 7 enables receiver
// (R4) line enable bit 6 enables transmitter
// (R5) line enable bit 4 enables start-of-frame detection
// (R6) line enable bit 3 selects open-drain output
// (R7) bits 2:1 select normal, double, generic auto or lin auto speed
// (R8) software writes speed field zero in async or infrared mode
// (R9) line enable bit 0 enables multi-node addressing
// (R10) frame format bits 7:6 select async, sync, infrared or host spi
// (R11) host spi view holds mode, bit order and clock phase; resets 0x02
// (R12) parity field 5:4: none, reserved, even, odd
// (R13) bit 3 gives transmitter one or two stop bits; receiver ignores
// (R14) bits 2:0 give 5 to 8 or 9 bit characters, two nine-bit orders
// (R15) host spi bit order: 0 msb first, 1 lsb first
// (R16) software changes bit order only when no transfer runs
// (R17) host spi clock phase: 0 leading edge, 1 trailing; resets 1
// (R18) normal frame format resets to 0x03, line enable to zero
// (R19) bad sync flag set on bad sync length or lin sync not 0x55; code sets it only while line enable bit 2 selects an auto speed
// (R20) nine-bit low first: high byte write starts shift, else low byte
// (R21) software avoids reserved parity and width codes
`default_nettype none
module uart_control_config
   import uart_cfg_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   input  wire logic       sync_too_short_i,
   input  wire logic       sync_too_long_i,
   input  wire logic       sync_char_valid_i,
   input  wire logic [7:0] sync_char_i,
   output logic            baud_error_irq_o,
   output logic            tx_load_o,
   output var line_config_s config_o
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] line_ctrl;
   logic [7:0] line_enable_control;
   logic [7:0] frame_format_control;
   logic       bad_sync_field_flag;
   logic       auto_baud;
   logic       spi_now;
   logic       bad_sync_event;
   logic       bad_sync_clear;
   logic [7:0] next_rdata;

   function automatic logic [3:0] width_bits(input logic [2:0] code);
      unique case (code)
         3'b000: width_bits = 4'h5;
         3'b001: width_bits = 4'h6;
         3'b010: width_bits = 4'h7;
         3'b011: width_bits = 4'h8;
         3'b110, 3'b111: width_bits = 4'h9; // R14
         default: width_bits = 4'h8;
      endcase
   endfunction

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         line_ctrl <= RESET_LINE_CTRL;
      end else if (wr_i && addr_i == ADDR_LINE_CTRL) begin
         line_ctrl <= wdata_i & MASK_LINE_CTRL; // R2
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         line_enable_control <= RESET_LINE_ENABLE; // R18
      end else if (wr_i && addr_i == ADDR_LINE_ENABLE) begin
         line_enable_control <= wdata_i & MASK_LINE_ENABLE;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         frame_format_control <= RESET_FRAME; // R18
      end else if (wr_i && addr_i == ADDR_FRAME_FORMAT) begin
         if (wdata_i[7:6] == LINK_HOST_SPI) begin
            frame_format_control <= wdata_i & MASK_SPI_VIEW; // R11
         end else begin
            frame_format_control <= wdata_i; // R10
         end
      end
   end

   // ---------------------------------------------------------------
   // bad sync flag, set wins over write-one clear
   // ---------------------------------------------------------------
   assign spi_now   = frame_format_control[7:6] == LINK_HOST_SPI;
   assign auto_baud = line_enable_control[2];
   assign bad_sync_event = auto_baud && (sync_too_short_i || sync_too_long_i
                         || (line_enable_control[2:1] == SPEED_LIN_AUTO && sync_char_valid_i
                             && sync_char_i != SYNC_CHAR)); // R19
   assign bad_sync_clear = wr_i && addr_i == ADDR_STATUS && wdata_i[BIT_BAD_SYNC];

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         bad_sync_field_flag <= 1'b0;
      end else if (bad_sync_event) begin
         bad_sync_field_flag <= 1'b1; // R19
      end else if (bad_sync_clear) begin
         bad_sync_field_flag <= 1'b0;
      end
   end

   assign baud_error_irq_o = bad_sync_field_flag && line_ctrl[BIT_BAUD_ERR_IE]; // R1

   // ---------------------------------------------------------------
   // transmit load strobe
   // ---------------------------------------------------------------
   always_comb begin
      if (frame_format_control[2:0] == NINE_BIT_LOW_FIRST && !spi_now) begin
         tx_load_o = wr_i && addr_i == ADDR_TX_HIGH; // R20
      end else begin
         tx_load_o = wr_i && addr_i == ADDR_TX_LOW; // R20
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   always_comb begin
      next_rdata = 8'h00;
      unique case (addr_i)
         ADDR_LINE_CTRL:    next_rdata = line_ctrl;
         ADDR_LINE_ENABLE:  next_rdata = line_enable_control;
         ADDR_FRAME_FORMAT: next_rdata = frame_format_control;
         ADDR_STATUS:       next_rdata = {4'h0, bad_sync_field_flag, 3'h0};
         default:           next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // decoded configuration
   // ---------------------------------------------------------------
   always_comb begin
      config_o.receiver_on           = line_enable_control[BIT_RX_ON];      // R3
      config_o.transmitter_on        = line_enable_control[BIT_TX_ON];      // R4
      config_o.frame_start_detect_on = line_enable_control[BIT_SFD_ON];     // R5
      config_o.open_drain_on         = line_enable_control[BIT_OPEN_DRAIN]; // R6
      config_o.receiver_speed_select = receiver_speed_select_e'(line_enable_control[2:1]); // R7
      config_o.multi_node_addressing = line_enable_control[BIT_MULTI_NODE]; // R9
      config_o.rs485_on              = line_ctrl[BIT_RS485];                // R2
      config_o.link_mode_select      = link_mode_select_e'(frame_format_control[7:6]); // R10
      config_o.parity_select         = spi_now ? PARITY_NONE
                                     : parity_select_e'(frame_format_control[5:4]); // R12
      config_o.two_stop_bits         = !spi_now && frame_format_control[BIT_STOP_COUNT]; // R13
      config_o.character_width       = spi_now ? WIDTH_8
                                     : character_width_e'(frame_format_control[2:0]); // R14
      config_o.data_bits             = spi_now ? 4'h8 : width_bits(frame_format_control[2:0]);
      config_o.lsb_first             = spi_now && frame_format_control[BIT_BIT_ORDER];     // R15
      config_o.sample_trailing       = spi_now && frame_format_control[BIT_CLOCK_PHASE];   // R17
   end
endmodule
`default_nettype wire

// >>> sim/uart_control_config_monitor.sv
// assertion checker for the serial control block
`default_nettype none
module uart_control_config_monitor
   import uart_cfg_pkg::*;
(
   input wire logic         clock_i,
   input wire logic         rst_i,
   input wire logic [3:0]   addr_i,
   input wire logic [7:0]   wdata_i,
   input wire logic         wr_i,
   input wire logic         sync_too_short_i,
   input wire logic         sync_too_long_i,
   input wire logic         sync_char_valid_i,
   input wire logic         baud_error_irq_o,
   input wire logic         tx_load_o,
   input wire line_config_s config_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------------
   // register write effects, interrupt cause and reset values
   // ---------------------------------------------------------------
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   wire logic w_en  = wr_i && addr_i == ADDR_LINE_ENABLE;
   wire logic w_fmt = wr_i && addr_i == ADDR_FRAME_FORMAT;
   wire logic w_ctl = wr_i && addr_i == ADDR_LINE_CTRL;
   wire logic sync_ev = sync_too_short_i || sync_too_long_i || sync_char_valid_i;
   chk_rx_enable: assert property (w_en |=> config_o.receiver_on == $past(wdata_i[7]))
      else $error("receiver enable not taken");
   chk_tx_enable: assert property (w_en |=> config_o.transmitter_on == $past(wdata_i[6]))
      else $error("transmitter enable not taken");
   chk_speed_write: assert property (w_en |=> config_o.receiver_speed_select == $past(wdata_i[2:1]))
      else $error("receiver speed not taken");
   chk_mode_write: assert property (w_fmt |=> config_o.link_mode_select == $past(wdata_i[7:6]))
      else $error("link mode not taken");
   chk_rs485_write: assert property (w_ctl |=> config_o.rs485_on == $past(wdata_i[0]))
      else $error("rs485 bit not taken");
   chk_irq_cause: assert property ($rose(baud_error_irq_o) |-> $past(sync_ev || w_ctl))
      else $error("interrupt without cause");
   chk_load_high: assert property (wr_i && addr_i == ADDR_TX_HIGH
      |-> tx_load_o == (config_o.character_width == NINE_BIT_LOW_FIRST)) else $error("high byte load wrong");
   chk_reset_frame: assert property ($fell(rst_i) |-> config_o.character_width == WIDTH_8
      && config_o.link_mode_select == LINK_ASYNC && !config_o.receiver_on) else $error("reset config wrong");
endmodule
bind uart_control_config uart_control_config_monitor mon_u (.clock_i(clock_i), .rst_i(rst_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .sync_too_short_i(sync_too_short_i),
   .sync_too_long_i(sync_too_long_i), .sync_char_valid_i(sync_char_valid_i),
   .baud_error_irq_o(baud_error_irq_o), .tx_load_o(tx_load_o), .config_o(config_o));
`default_nettype wire

// >>> sim/sync_node_model.sv
// remote node model: sync field events seen by the auto-baud engine
`default_nettype none
module sync_node_model (
   input  wire logic       clock_i,
   input  wire logic [1:0] event_i,
   input  wire logic [7:0] char_i,
   output logic            too_short_o,
   output logic            too_long_o,
   output logic            char_valid_o,
   output logic      [7:0] char_o = 8'h00
);
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------------
   // one-cycle event pulses, character changes when not valid
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      too_short_o  <= event_i == 2'h1;
      too_long_o   <= event_i == 2'h2;
      char_valid_o <= event_i == 2'h3;
      char_o       <= (event_i == 2'h3) ? char_i : ~char_o;
   end
endmodule
`default_nettype wire

// >>> sim/uart_control_config_test.sv
// self-checking bench for the serial control block
`default_nettype none
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
   $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module uart_control_config_test import uart_cfg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i, rst_i, wr_i, rd_i, load_seen, t_short, t_long, c_valid, irq, tx_load;
   logic [3:0] addr_i;
   logic [7:0] wdata_i, rdata_o, s_char, ev_char, d;
   logic [1:0] ev;
   logic [31:0] seed = 32'h0000_34bf;
   line_config_s cfg;
   int fail_count, checks_done;
   sync_node_model node_u (.clock_i(clock_i), .event_i(ev), .char_i(ev_char), .too_short_o(t_short),
      .too_long_o(t_long), .char_valid_o(c_valid), .char_o(s_char));
   uart_control_config dut_u (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sync_too_short_i(t_short), .sync_too_long_i(t_long),
      .sync_char_valid_i(c_valid), .sync_char_i(s_char), .baud_error_irq_o(irq), .tx_load_o(tx_load),
      .config_o(cfg));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      #1 load_seen = tx_load;
      @(posedge clock_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 `CK(rdata_o, e)
   endtask
   task automatic sync_event(input logic [1:0] k, input logic [7:0] c, input logic e);
      @(posedge clock_i);
      ev <= k;
      ev_char <= c;
      @(posedge clock_i);
      ev <= 2'h0;
      repeat (3) @(posedge clock_i);
      #1 `CK(irq, e)
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   initial begin
      #500_000;
      fail_count++;
      close_out;
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {rst_i, wr_i, rd_i, addr_i, wdata_i, ev, ev_char} = {1'b1, 24'h0};
      repeat (12) @(posedge clock_i);
      rst_i <= 1'b0;
      rd(ADDR_LINE_ENABLE, 8'h00);
      rd(ADDR_FRAME_FORMAT, 8'h03);
      rd(4'hF, 8'h00);
      for (int m = 0; m < 4; m++) begin
         seed = lfsr(seed);
         d = {m[1:0], seed[5:4] == 2'h1 ? 2'h0 : seed[5:4], seed[3], seed[2:1] == 2'h2 ? 2'h0 : seed[2:1], seed[0]};
         wr(ADDR_FRAME_FORMAT, d);
         rd(ADDR_FRAME_FORMAT, (m == 3) ? d & 8'hC6 : d);
         `CK(cfg.link_mode_select, d[7:6])
         if (m == 3) begin
            `CK({cfg.lsb_first, cfg.sample_trailing}, d[2:1])
         end else begin
            `CK({cfg.parity_select, cfg.two_stop_bits, cfg.character_width}, d[5:0])
            `CK(cfg.data_bits, (d[2:0] < 3'h4) ? 4'h5 + d[2:0] : 4'h9)
         end
      end
      $display("frame format done");
      wr(ADDR_FRAME_FORMAT, 8'h43);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         d = seed[7:0];
         wr(ADDR_LINE_ENABLE, d);
         wr(ADDR_LINE_CTRL, d & 8'h01);
         `CK(cfg.rs485_on, d[0])
         `CK({cfg.receiver_on, cfg.transmitter_on, cfg.frame_start_detect_on}, {d[7:6], d[4]})
         `CK({cfg.open_drain_on, cfg.receiver_speed_select, cfg.multi_node_addressing}, d[3:0])
         rd(ADDR_LINE_ENABLE, d & 8'hDF);
         rd(ADDR_LINE_CTRL, d & 8'h01);
      end
      $display("line enable done");
      wr(ADDR_LINE_ENABLE, 8'h04);
      wr(ADDR_LINE_CTRL, 8'h04);
      sync_event(2'h1, 8'h00, 1'b1);
      rd(ADDR_STATUS, 8'h08);
      wr(ADDR_STATUS, 8'h08);
      `CK(irq, 1'b0)
      rd(ADDR_STATUS, 8'h00);
      wr(ADDR_LINE_CTRL, 8'h00);
      sync_event(2'h2, 8'h00, 1'b0);
      wr(ADDR_LINE_CTRL, 8'h04);
      `CK(irq, 1'b1)
      wr(ADDR_STATUS, 8'h08);
      wr(ADDR_LINE_ENABLE, 8'h06);
      sync_event(2'h3, 8'h55, 1'b0);
      sync_event(2'h3, 8'h54, 1'b1);
      wr(ADDR_STATUS, 8'h08);
      wr(ADDR_LINE_ENABLE, 8'h02);
      sync_event(2'h1, 8'h00, 1'b0);
      $display("auto-baud interrupt done");
      wr(ADDR_FRAME_FORMAT, 8'h46);
      wr(ADDR_TX_HIGH, 8'h01);
      `CK(load_seen, 1'b1)
      wr(ADDR_TX_LOW, 8'h5A);
      `CK(load_seen, 1'b0)
      wr(ADDR_FRAME_FORMAT, 8'h47);
      wr(ADDR_TX_LOW, 8'h5A);
      `CK(load_seen, 1'b1)
      $display("transmit load done");
      close_out;
   end
endmodule
`default_nettype wire
